//--- rtl/mmc_mgmt_ctrl.v
`timescale 1ns/1ps
`include "mmc_defines.vh"

// Summary of operation
// - Soft reset does all hard reset does, but base register keeps value.
// - Soft reset is active high, asynchronous, synchronised before use.
// - Falling management interrupt edge enters management mode after instruction.
// - Management interrupt taken at instruction boundaries and string iterations.
// - Locked bus sequences finish before management mode entry.
// - Inside management mode, one further falling edge is held pending.
// - Pending nested interrupt serviced only after resume instruction.
// - Active output goes low when state save starts.
// - Active output stays low until last state restore cycle completes.
// - Clock-stop request halts at next instruction boundary unless higher interrupt wins.
// - After halting, drain pipelines and buffers, then issue stop grant.
module mmc_mgmt_ctrl #(
    parameter DRAIN_CLKS = `MMC_DRAIN_CLKS
) (
    // Clock and hard reset
    input  wire                   clk_sys,
    input  wire                   rst_n,
    // Pins from the system controller (asynchronous)
    input  wire                   softResetIn,
    input  wire                   mgmtInterruptN,
    input  wire                   clockStopRequestN,
    // Core status
    input  wire                   instrBoundary,
    input  wire                   stringIterBoundary,
    input  wire                   lockedSeqActive,
    input  wire                   higherIntPending,
    input  wire                   saveDone,
    input  wire                   resumeFromMgmt,
    input  wire                   restoreLastDone,
    // Base register load, from the state save area image
    input  wire                   baseLoad,
    input  wire [`MMC_BASE_W-1:0] baseLoadValue,
    // Outputs
    output reg                    mgmtActiveN,
    output reg                    systemManagementMode,
    output reg                    mgmtPending,
    output reg                    coreHalt,
    output reg                    stopGrantCycle,
    output reg                    coreResetOut,
    output reg  [`MMC_BASE_W-1:0] mgmtStateBase
);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    // Each pin passes its own three-stage filter. Every filter
    // resets to its pin's idle level, so leaving hard reset can
    // never fake a soft reset, an interrupt edge or a stop request
    wire srstLvl;
    wire smiFall;
    wire stopLvl;

    mmc_pin_sync #(
        .RESET_LVL (1'b0)
    ) i_srstSync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pinIn   (softResetIn),
        .lvlOut  (srstLvl),
        .fallOut ()
    );

    mmc_pin_sync #(
        .RESET_LVL (1'b1)
    ) i_smiSync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pinIn   (mgmtInterruptN),
        .lvlOut  (),
        .fallOut (smiFall)
    );

    mmc_pin_sync #(
        .RESET_LVL (1'b1)
    ) i_stopSync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pinIn   (clockStopRequestN),
        .lvlOut  (stopLvl),
        .fallOut ()
    );

    // Soft reset acts as a synchronous reset of all control state
    wire softRst = srstLvl;

    // Request is inverted to active high; the controller keeps it until grant
    wire stopReq = ~stopLvl;

    // ==========================================================
    // Control state machine
    // ==========================================================
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg       edgeLatch_ff;
    reg       nestPend_ff;
    reg [7:0] drainCnt_ff;

    // A locked sequence defers both interrupt entry and clock stop
    wire takePoint = (instrBoundary | stringIterBoundary)
                     & ~lockedSeqActive;
    wire inMgmt    = (state_ff == `MMC_ST_SAVE)
                   | (state_ff == `MMC_ST_MGMT)
                   | (state_ff == `MMC_ST_RESTORE);
    wire smiWant   = edgeLatch_ff | (smiFall & ~inMgmt);

    // A fresh edge in the very cycle that a latched one is taken
    // belongs to the session just starting, so it is held as nested
    wire smiNest   = smiFall & (inMgmt
                   | (edgeLatch_ff & (nxt_state == `MMC_ST_SAVE)));

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            `MMC_ST_RUN: begin
                // Interrupt entry outranks a clock stop
                if (smiWant && takePoint) begin
                    nxt_state = `MMC_ST_SAVE;
                end else if (stopReq && instrBoundary &&
                             !higherIntPending && !lockedSeqActive) begin
                    nxt_state = `MMC_ST_DRAIN;
                end
            end
            `MMC_ST_SAVE: begin
                // Session pulses outside their own state are ignored
                if (saveDone) begin
                    nxt_state = `MMC_ST_MGMT;
                end
            end
            `MMC_ST_MGMT: begin
                if (resumeFromMgmt) begin
                    nxt_state = `MMC_ST_RESTORE;
                end
            end
            `MMC_ST_RESTORE: begin
                if (restoreLastDone) begin
                    nxt_state = `MMC_ST_RUN;
                end
            end
            `MMC_ST_DRAIN: begin
                if (drainCnt_ff == 8'h00) begin
                    nxt_state = `MMC_ST_GRANT;
                end
            end
            `MMC_ST_GRANT: begin
                // The grant cycle lasts one clock
                nxt_state = `MMC_ST_STOPPED;
            end
            `MMC_ST_STOPPED: begin
                // Release may come any time after the grant
                if (!stopReq) begin
                    nxt_state = `MMC_ST_RUN;
                end
            end
            default: begin
                // Unused code 7 falls back to normal running
                nxt_state = `MMC_ST_RUN;
            end
        endcase
    end

    // ==========================================================
    // State and pending-edge registers
    // ==========================================================
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff     <= `MMC_ST_RUN;
            edgeLatch_ff <= 1'b0;
            nestPend_ff  <= 1'b0;
            drainCnt_ff  <= 8'h00;
        end else if (softRst) begin
            state_ff     <= `MMC_ST_RUN;
            edgeLatch_ff <= 1'b0;
            nestPend_ff  <= 1'b0;
            drainCnt_ff  <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            // Edge seen outside management mode waits for a boundary
            if (nxt_state == `MMC_ST_SAVE) begin
                edgeLatch_ff <= 1'b0;
            end else if (smiFall && !inMgmt) begin
                edgeLatch_ff <= 1'b1;
            end
            // Only one nested edge is remembered; more are dropped.
            // On the restore-done cycle the stored edge, and any edge
            // arriving with it, move to the entry latch instead.
            if (state_ff == `MMC_ST_RESTORE && restoreLastDone) begin
                nestPend_ff <= 1'b0;
            end else if (smiNest) begin
                nestPend_ff <= 1'b1;
            end
            if (state_ff == `MMC_ST_RESTORE && restoreLastDone &&
                (nestPend_ff || smiFall)) begin
                edgeLatch_ff <= 1'b1;
            end
            // Loads on drain entry and counts to zero; the grant
            // follows in the cycle after zero is reached
            if (nxt_state == `MMC_ST_DRAIN && state_ff != `MMC_ST_DRAIN) begin
                drainCnt_ff <= DRAIN_CLKS[7:0] - 8'h01;
            end else if (drainCnt_ff != 8'h00) begin
                drainCnt_ff <= drainCnt_ff - 8'h01;
            end
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // State outputs are decoded from the next state, so they leave a flop
    // in step with the state register; mgmtPending and coreResetOut trail nestPend_ff and softRst by one cycle
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mgmtActiveN          <= 1'b1;
            systemManagementMode <= 1'b0;
            mgmtPending          <= 1'b0;
            coreHalt             <= 1'b0;
            stopGrantCycle       <= 1'b0;
            coreResetOut         <= 1'b1;
        end else begin
            // Soft reset forces each output to its hard-reset value
            mgmtActiveN          <= ~((nxt_state == `MMC_ST_SAVE)
                                    | (nxt_state == `MMC_ST_MGMT)
                                    | (nxt_state == `MMC_ST_RESTORE))
                                    | softRst;
            systemManagementMode <= ~softRst & (nxt_state != `MMC_ST_RUN)
                                    & (nxt_state != `MMC_ST_DRAIN)
                                    & (nxt_state != `MMC_ST_GRANT)
                                    & (nxt_state != `MMC_ST_STOPPED);
            mgmtPending          <= ~softRst & nestPend_ff;
            coreHalt             <= ~softRst
                                    & ((nxt_state == `MMC_ST_DRAIN)
                                    | (nxt_state == `MMC_ST_GRANT)
                                    | (nxt_state == `MMC_ST_STOPPED));
            stopGrantCycle       <= ~softRst
                                    & (nxt_state == `MMC_ST_GRANT);
            // Core reset follows the filtered soft reset level only
            coreResetOut         <= softRst;
        end
    end

    // ==========================================================
    // Base register
    // ==========================================================
    // Base register survives a soft reset, only hard reset restores it
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mgmtStateBase <= `MMC_BASE_RESET;
        end else if (baseLoad && !softRst) begin
            mgmtStateBase <= baseLoadValue;
        end
    end

endmodule // mmc_mgmt_ctrl

// ==========================================================
// Three-stage pin filter
// ==========================================================
// A change counts only once stages two and three agree, so a
// one-clock glitch that slips into the first stage is ignored.
module mmc_pin_sync #(
    parameter [0:0] RESET_LVL = 1'b1
) (
    // Clock and hard reset
    input  wire clk_sys,
    input  wire rst_n,
    // Raw pin in, filtered level and falling edge out
    input  wire pinIn,
    output wire lvlOut,
    output wire fallOut
);

    reg [2:0] sync_ff;
    reg       lvl_ff;

    // Stage one may go metastable; only stages two and three feed logic
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_ff <= {3{RESET_LVL}};
            lvl_ff  <= RESET_LVL;
        end else begin
            sync_ff <= {sync_ff[1:0], pinIn};
            if (sync_ff[1] == sync_ff[2]) begin
                lvl_ff <= sync_ff[2];
            end
        end
    end

    // One-clock event in the cycle before the level drops
    assign lvlOut  = lvl_ff;
    assign fallOut = lvl_ff & ~sync_ff[2] & ~sync_ff[1];

endmodule // mmc_pin_sync

//--- rtl/mmc_defines.vh
`ifndef MMC_DEFINES_VH
`define MMC_DEFINES_VH

// Soft reset minimum hold, in input-clock periods
`define MMC_SRST_MIN_CLKS     15
// Default management-state base after a hard reset
`define MMC_BASE_RESET        32'h0003_0000
`define MMC_BASE_W            32
// Cycles spent draining pipelines and write buffers before stop grant
`define MMC_DRAIN_CLKS        4

// Control states
`define MMC_ST_RUN            3'h0
`define MMC_ST_SAVE           3'h1
`define MMC_ST_MGMT           3'h2
`define MMC_ST_RESTORE        3'h3
`define MMC_ST_DRAIN          3'h4
`define MMC_ST_GRANT          3'h5
`define MMC_ST_STOPPED        3'h6

`endif

//--- sim/mmc_sysctl_model.sv
`timescale 1ns/1ps
// ==========================================
// System controller: drives the three pins
module mmc_sysctl_model (
    // Clock and grant seen on the bus
    input  wire  clk_sys,
    input  wire  stopGrantCycle,
    // Bench commands
    input  wire  doSmi,
    input  wire  doStop,
    input  wire  doSoft,
    // Pins
    output logic softResetIn,
    output logic mgmtInterruptN,
    output logic clockStopRequestN = 1'b1
);
    logic [4:0] softCnt_ff = 5'h00;
    logic [3:0] smiCnt_ff  = 4'h0;

    always @(posedge clk_sys) begin
        if (doSoft)
            softCnt_ff <= 5'h14;
        else if (softCnt_ff != 5'h00)
            softCnt_ff <= softCnt_ff - 5'h01;
        if (doSmi)
            smiCnt_ff <= 4'h8;
        else if (smiCnt_ff != 4'h0)
            smiCnt_ff <= smiCnt_ff - 4'h1;
        if (doStop)
            clockStopRequestN <= 1'b0;
        else if (stopGrantCycle)
            clockStopRequestN <= 1'b1;
    end

    assign softResetIn    = (softCnt_ff != 5'h00);
    assign mgmtInterruptN = (smiCnt_ff == 4'h0);
endmodule // mmc_sysctl_model

//--- sim/mmc_mgmt_ctrl_assertions.sv
`timescale 1ns/1ps
// ==========================================
// Port checks
module mmc_ctrl_checker #(
    parameter DRAIN_CLKS = 4
) (
    // Clock and reset
    input wire        clk_sys,
    input wire        rst_n,
    // Core status
    input wire        instrBoundary,
    input wire        stringIterBoundary,
    input wire        lockedSeqActive,
    input wire        higherIntPending,
    input wire        restoreLastDone,
    // Outputs
    input wire        mgmtActiveN,
    input wire        systemManagementMode,
    input wire        mgmtPending,
    input wire        coreHalt,
    input wire        stopGrantCycle,
    input wire        coreResetOut,
    input wire [31:0] mgmtStateBase
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence entry_ok;
        $past(instrBoundary | stringIterBoundary) && !$past(lockedSeqActive);
    endsequence
    sequence in_session;
        !mgmtActiveN && !restoreLastDone && !coreResetOut;
    endsequence

    mode_flag_a: assert property (mgmtActiveN != systemManagementMode)
        else $error("mode flag disagrees with active output");
    entry_gate_a: assert property ($fell(mgmtActiveN) |-> entry_ok)
        else $error("entry outside a boundary or inside locked cycles");
    active_hold_a: assert property (in_session |=> !mgmtActiveN || coreResetOut)
        else $error("active output released before final restore");
    halt_gate_a: assert property ($rose(coreHalt) |->
        $past(instrBoundary) && !$past(higherIntPending))
        else $error("halt without boundary or over higher interrupt");
    grant_pulse_a: assert property (stopGrantCycle |=> !stopGrantCycle)
        else $error("stop grant longer than one cycle");
    grant_drain_a: assert property (stopGrantCycle |->
        coreHalt && $past(coreHalt, DRAIN_CLKS))
        else $error("stop grant before draining");
    reset_clear_a: assert property (coreResetOut |=>
        mgmtActiveN && !mgmtPending && !coreHalt)
        else $error("state not cleared by reset");
    base_keep_a: assert property (coreResetOut |=> $stable(mgmtStateBase))
        else $error("base changed by soft reset");
    pend_in_mgmt_a: assert property ($rose(mgmtPending) |->
        !mgmtActiveN || $past(!mgmtActiveN))
        else $error("pending stored outside management");
endmodule // mmc_ctrl_checker

bind mmc_mgmt_ctrl mmc_ctrl_checker #(.DRAIN_CLKS(DRAIN_CLKS)) i_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .instrBoundary(instrBoundary),
    .stringIterBoundary(stringIterBoundary), .lockedSeqActive(lockedSeqActive),
    .higherIntPending(higherIntPending), .restoreLastDone(restoreLastDone),
    .mgmtActiveN(mgmtActiveN), .systemManagementMode(systemManagementMode),
    .mgmtPending(mgmtPending), .coreHalt(coreHalt),
    .stopGrantCycle(stopGrantCycle), .coreResetOut(coreResetOut),
    .mgmtStateBase(mgmtStateBase));

//--- sim/tb_mgmt_mode_and_clock_stop_control.sv
`timescale 1ns/1ps
`include "mmc_defines.vh"
module tb_mgmt_mode_and_clock_stop_control;
    logic        clk_sys = 1'b0, rst_n = 1'b0, instrBoundary = 1'b0;
    logic        stringIterBoundary = 1'b0, lockedSeqActive = 1'b0;
    logic        higherIntPending = 1'b0, saveDone = 1'b0, baseLoad = 1'b0;
    logic        resumeFromMgmt = 1'b0, restoreLastDone = 1'b0;
    logic        doSmi = 1'b0, doStop = 1'b0, doSoft = 1'b0;
    logic [31:0] baseLoadValue = 32'h0000_0000;
    wire         softResetIn, mgmtInterruptN, clockStopRequestN, mgmtActiveN;
    wire         systemManagementMode, mgmtPending, coreHalt, stopGrantCycle;
    wire         coreResetOut;
    wire  [31:0] mgmtStateBase;
    int          num_errors = 0, n_compared = 0;
    // Row: boundary, string, locked, higher, stop, active_n, halt
    logic [6:0]  rows [6] = '{7'h40, 7'h20, 7'h52, 7'h02, 7'h47, 7'h4E};

    initial forever #2.5 clk_sys = ~clk_sys;

    mmc_sysctl_model i_sys (.clk_sys(clk_sys), .stopGrantCycle(stopGrantCycle),
        .doSmi(doSmi), .doStop(doStop), .doSoft(doSoft),
        .softResetIn(softResetIn), .mgmtInterruptN(mgmtInterruptN),
        .clockStopRequestN(clockStopRequestN));
    mmc_mgmt_ctrl #(.DRAIN_CLKS(4)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .softResetIn(softResetIn), .mgmtInterruptN(mgmtInterruptN),
        .clockStopRequestN(clockStopRequestN), .instrBoundary(instrBoundary),
        .stringIterBoundary(stringIterBoundary), .saveDone(saveDone),
        .lockedSeqActive(lockedSeqActive), .higherIntPending(higherIntPending),
        .resumeFromMgmt(resumeFromMgmt), .restoreLastDone(restoreLastDone),
        .baseLoad(baseLoad), .baseLoadValue(baseLoadValue),
        .mgmtActiveN(mgmtActiveN), .systemManagementMode(systemManagementMode),
        .mgmtPending(mgmtPending), .coreHalt(coreHalt),
        .stopGrantCycle(stopGrantCycle), .coreResetOut(coreResetOut),
        .mgmtStateBase(mgmtStateBase));

    // ==========================================
    // Helpers
    task chk1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task chk32(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t base %h expected %h", $time, got, exp);
        end
    endtask
    // Pin latency is a few clocks, so settle ten before looking
    task req(input logic [2:0] k);
        @(posedge clk_sys) {doSoft, doStop, doSmi} <= k;
        @(posedge clk_sys) {doSoft, doStop, doSmi} <= 3'h0;
        repeat (9) @(posedge clk_sys);
        #1;
    endtask
    task finish_mgmt;
        @(posedge clk_sys) saveDone <= 1'b1;
        @(posedge clk_sys) saveDone <= 1'b0;
        repeat (2) @(posedge clk_sys) resumeFromMgmt <= ~resumeFromMgmt;
        repeat (2) @(posedge clk_sys);
        #1 chk1(mgmtActiveN, 1'b0);
        chk1(systemManagementMode, 1'b1);
        @(posedge clk_sys) restoreLastDone <= 1'b1;
        @(posedge clk_sys) restoreLastDone <= 1'b0;
    endtask
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge clk_sys);
        num_errors++;
        report_and_stop;
    end

    // ==========================================
    // Tests
    initial begin
        repeat (2) @(posedge clk_sys);
        #1 chk1(coreResetOut, 1'b1);
        chk32(mgmtStateBase, `MMC_BASE_RESET);
        chk1(mgmtActiveN, 1'b1);
        @(posedge clk_sys) rst_n <= 1'b1;
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys) {instrBoundary, stringIterBoundary,
                lockedSeqActive, higherIntPending} <= rows[i][6:3];
            req({1'b0, rows[i][2], !rows[i][2]});
            chk1(mgmtActiveN, rows[i][1]);
            chk1(coreHalt, rows[i][0]);
            chk1(stopGrantCycle, rows[i][0]);
            @(posedge clk_sys) {instrBoundary, stringIterBoundary,
                lockedSeqActive, higherIntPending} <= 4'h8;
            repeat (25) @(posedge clk_sys);
            if (mgmtActiveN === 1'b0)
                finish_mgmt;
            repeat (25) @(posedge clk_sys);
            #1 chk1(mgmtActiveN & !coreHalt, 1'b1);
            $display("row %0d done", i);
        end
        // Nested edges: one kept, one dropped
        req(3'h1);
        req(3'h1);
        req(3'h1);
        chk1(mgmtPending, 1'b1);
        finish_mgmt;
        repeat (6) @(posedge clk_sys);
        #1 chk1(mgmtActiveN, 1'b0);
        chk1(mgmtPending, 1'b0);
        finish_mgmt;
        repeat (12) @(posedge clk_sys);
        #1 chk1(mgmtActiveN, 1'b1);
        $display("nested test done");
        // Soft reset in mid-session keeps the loaded base
        @(posedge clk_sys) baseLoadValue <= 32'h000A_0000;
        baseLoad <= 1'b1;
        @(posedge clk_sys) baseLoad <= 1'b0;
        req(3'h1);
        req(3'h4);
        chk1(coreResetOut, 1'b1);
        repeat (25) @(posedge clk_sys);
        #1 chk1(mgmtActiveN & !mgmtPending & !coreResetOut, 1'b1);
        chk32(mgmtStateBase, 32'h000A_0000);
        $display("soft reset test done");
        report_and_stop;
    end
endmodule // tb_mgmt_mode_and_clock_stop_control
